// [shared/pwrdn_map.svh]
// constants of the power-down controller: register map, field positions, reset values
// assumes a 32-bit classic Wishbone slave port with byte-addressed words
// Overview of operation
// (R1) halt-wait with standby_select clear enters sleep; clock runs, cpu halts, state kept
// (R2) halt-wait with standby_select set enters standby; clock, cpu and peripherals halt
// (R3) cpu stops right after halt-wait completes; its registers stay unchanged
// (R4) in sleep the peripherals keep their clock and keep running
// (R5) an accepted interrupt ends sleep and starts interrupt exception processing
// (R6) interrupts at or below the mask level, or disabled at source, do not wake
// (R7) a dma or transfer unit address error ends sleep and starts its exception
// (R8) power_on_reset_n low gives a power-on reset that ends sleep
// (R9) manual_reset_n low with power_on_reset_n high gives a manual reset ending sleep
// (R10) standby ends only by power-on reset; nothing else wakes it
// (R11) writing standby_select to one is ignored while watchdog_run_enable is one
// (R12) writing port_float_select to one is ignored while watchdog_run_enable is one
// (R13) software stops the watchdog before setting standby_select or port_float_select
// (R14) port_float_select chooses held pins or high impedance ports in standby
// (R15) control register resets to 1F; standby_select bit 7, port_float_select bit 6
// (R16) bit 5 reads zero, bits 4 to 0 read one; software writes the same
// (R17) a power-on reset also returns the control register to its reset value
`ifndef PWRDN_MAP_SVH
`define PWRDN_MAP_SVH
`define PDC_OFFSET 32'hFFFF8614
`define PDC_WORD_ADDR 32'hFFFF8614
`define PDC_RESET 8'h1F
`define PDC_STBY_BIT 7
`define PDC_FLOAT_BIT 6
`define PDC_FIXED_ONES 8'h1F
`define PDC_RSVD_MASK 8'h3F
`define STAT_OFFSET 32'hFFFF8618
`define SYNC_DEPTH 3
`define PRIO_W 4
`endif

// [shared/pwrdn_pkg.sv]
// types of the power-down controller
// assumes pwrdn_map.svh for numeric constants
package pwrdn_pkg;
    typedef enum logic [2:0] {
        RUN_ST = 3'b001,
        SLEEP_ST = 3'b010,
        STANDBY_ST = 3'b100
    } mode_type;

    typedef struct packed {
        logic stby_sel;
        logic float_sel;
    } ctrl_type;

    typedef struct packed {
        logic run_n;
        logic cpu_halt;
        logic clk_stop;
        logic periph_stop;
        logic port_float;
        logic wake_irq;
        logic wake_addr_err;
        logic wake_reset;
    } pwr_out_type;
endpackage : pwrdn_pkg

// [src/pin_sync.sv]
// three-stage synchroniser for asynchronous pins; change counts when stages 2 and 3 agree
// assumes a single clock and synchronous active-high reset
module pin_sync
    import pwrdn_pkg::*;
#(
    parameter int WIDTH = 2,
    parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    // a zero-width bus would leave nothing to synchronise
    if (WIDTH < 1) begin : g_width_check
        $error("pin_sync width must be at least 1");
    end
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] level;
    } sync_state_type;

    sync_state_type state;
    sync_state_type next_state;

    // first stage feeds only the second
    always_comb begin
        next_state = state;
        next_state.s1 = async_i;
        next_state.s2 = state.s1;
        next_state.s3 = state.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (state.s2[i] == state.s3[i]) begin
                next_state.level[i] = state.s3[i];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= {4{RESET_VAL}};
        end else begin
            state <= next_state;
        end
    end

    assign sync_o = state.level;
endmodule : pin_sync

// [src/power_down_mode_control.sv]
// power-down mode controller: sleep and standby entry, wake-up, control register
// assumes a cpu strobe for halt-wait completion, interrupt priorities from the controller,
// and a Wishbone master; reset pins are asynchronous and synchronised here
//
// Added by the designer: the Wishbone slave port.
`include "pwrdn_map.svh"
module power_down_mode_control
    import pwrdn_pkg::*;
#(
    parameter int PRIO_WIDTH = `PRIO_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // classic Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [31:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // cpu and system side
    input wire logic halt_wait_done_i,
    input wire logic watchdog_run_enable_i,
    input wire logic irq_pending_i,
    input wire logic irq_source_enabled_i,
    input wire logic [PRIO_WIDTH-1:0] irq_priority_i,
    input wire logic [PRIO_WIDTH-1:0] irq_mask_level_i,
    input wire logic dma_addr_err_i,
    input wire logic transfer_addr_err_i,
    input wire logic power_on_reset_n_i,
    input wire logic manual_reset_n_i,
    output logic cpu_halt_o,
    output logic clock_stop_o,
    output logic periph_stop_o,
    output logic port_float_o,
    output logic wake_irq_o,
    output logic wake_addr_err_o,
    output logic power_on_reset_o,
    output logic manual_reset_o,
    output logic [2:0] mode_o
);
    // elaboration check: the mask compare is only sized for small priority fields
    if (PRIO_WIDTH < 1 || PRIO_WIDTH > 8) begin : g_prio_check
        $error("priority width must be 1 to 8");
    end

    typedef struct packed {
        mode_type mode;
        ctrl_type ctrl;
        logic ack;
        logic [31:0] rdata;
        logic cpu_halt;
        logic clk_stop;
        logic periph_stop;
        logic port_float;
        logic wake_irq;
        logic wake_addr_err;
        logic por;
        logic manual_reset_n;
    } state_type;

    state_type state;
    state_type next_state;
    logic [1:0] pins_sync;
    logic por_active;
    logic manual_reset_n_active;
    logic irq_accept;
    logic hit_ctrl;
    logic hit_stat;
    logic wr_lane0;

    // reset pins arrive from outside the clock domain
    pin_sync #(
        .WIDTH(2),
        .RESET_VAL(2'h3)
    ) u_pin_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i({power_on_reset_n_i, manual_reset_n_i}),
        .sync_o(pins_sync)
    );

    // reset decode: manual reset only counts with power-on reset released
    assign por_active = ~pins_sync[1]; // [R8]
    assign manual_reset_n_active = pins_sync[1] & ~pins_sync[0]; // [R9]
    // interrupt wakes only if enabled at source and above the mask level
    assign irq_accept = irq_pending_i & irq_source_enabled_i
        & (irq_priority_i > irq_mask_level_i); // [R6]

    // word-aligned address decode; the low byte lane holds the 8-bit register
    function automatic logic addr_hit(input logic [31:0] adr, input logic [31:0] base);
        addr_hit = (adr[31:2] == base[31:2]);
    endfunction : addr_hit

    assign hit_ctrl = addr_hit(adr_i, `PDC_OFFSET);
    assign hit_stat = addr_hit(adr_i, `STAT_OFFSET);
    // ~ack keeps a request that is still held from writing a second time
    assign wr_lane0 = cyc_i & stb_i & we_i & ~state.ack & hit_ctrl & sel_i[0];

    // read view of the control register with fixed reserved bits
    function automatic logic [7:0] ctrl_view(input ctrl_type c);
        ctrl_view = `PDC_FIXED_ONES; // [R16]
        ctrl_view[`PDC_STBY_BIT] = c.stby_sel;
        ctrl_view[`PDC_FLOAT_BIT] = c.float_sel;
    endfunction : ctrl_view

    // bus answer checks: one ack per request, fixed reserved bits, guarded writes
    bus_answer_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
        (cyc_i && stb_i && !state.ack) |=> state.ack)
        else $error("bus request not answered");

    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
        state.ack |=> !state.ack)
        else $error("ack longer than one cycle");

    idle_ack_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
        !(cyc_i && stb_i) |=> !state.ack)
        else $error("ack without request");

    reserved_read_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R16]
        (cyc_i && stb_i && !state.ack && hit_ctrl)
        |=> ((state.rdata[`PDC_STBY_BIT:0] & `PDC_RSVD_MASK) == `PDC_FIXED_ONES))
        else $error("reserved bits read wrong");

    upper_read_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
        (cyc_i && stb_i && !state.ack && hit_ctrl)
        |=> state.rdata[31:`PDC_STBY_BIT+1] == '0)
        else $error("upper read bits not zero");

    clear_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
        (wr_lane0 && !dat_i[`PDC_STBY_BIT] && !por_active) |=> !state.ctrl.stby_sel)
        else $error("standby_select clear lost");

    open_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
        (wr_lane0 && dat_i[`PDC_STBY_BIT] && !watchdog_run_enable_i && !por_active)
        |=> state.ctrl.stby_sel)
        else $error("standby_select write lost");

    float_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
        (wr_lane0 && dat_i[`PDC_FLOAT_BIT] && !watchdog_run_enable_i && !por_active)
        |=> state.ctrl.float_sel)
        else $error("port_float_select write lost");

    // next-state logic for mode machine, register file and bus answer
    always_comb begin
        next_state = state;
        next_state.ack = 1'b0;
        next_state.wake_irq = 1'b0;
        next_state.wake_addr_err = 1'b0;
        next_state.por = por_active;
        next_state.manual_reset_n = manual_reset_n_active;
        // bus: one wait state, ack for one cycle, unmapped reads give zero
        if (cyc_i && stb_i && !state.ack) begin
            next_state.ack = 1'b1;
            next_state.rdata = 32'h0000_0000;
            if (hit_ctrl) begin
                next_state.rdata = {24'h000000, ctrl_view(state.ctrl)};
            end else if (hit_stat) begin
                next_state.rdata = {29'h0000_0000, state.mode};
            end
        end
        // writes to one are held off while the watchdog runs; clearing always works
        if (wr_lane0) begin
            if (!dat_i[`PDC_STBY_BIT] || !watchdog_run_enable_i) begin
                next_state.ctrl.stby_sel = dat_i[`PDC_STBY_BIT]; // [R11] [R15]
            end
            if (!dat_i[`PDC_FLOAT_BIT] || !watchdog_run_enable_i) begin
                next_state.ctrl.float_sel = dat_i[`PDC_FLOAT_BIT]; // [R12] [R15]
            end
        end
        unique case (state.mode)
            RUN_ST: begin
                // a reset pin in flight beats the halt strobe, so the cpu is never stranded
                if (halt_wait_done_i && !por_active && !manual_reset_n_active) begin
                    next_state.cpu_halt = 1'b1; // [R3]
                    if (state.ctrl.stby_sel) begin
                        next_state.mode = STANDBY_ST; // [R2]
                        next_state.clk_stop = 1'b1;
                        next_state.periph_stop = 1'b1;
                        next_state.port_float = state.ctrl.float_sel; // [R14]
                    end else begin
                        next_state.mode = SLEEP_ST; // [R1] [R4]
                    end
                end
            end
            SLEEP_ST: begin
                // priority: reset over address error over interrupt
                if (por_active || manual_reset_n_active) begin
                    next_state.mode = RUN_ST; // [R8] [R9]
                    next_state.cpu_halt = 1'b0;
                end else if (dma_addr_err_i || transfer_addr_err_i) begin
                    next_state.mode = RUN_ST; // [R7]
                    next_state.cpu_halt = 1'b0;
                    next_state.wake_addr_err = 1'b1;
                end else if (irq_accept) begin
                    next_state.mode = RUN_ST; // [R5]
                    next_state.cpu_halt = 1'b0;
                    next_state.wake_irq = 1'b1;
                end
            end
            STANDBY_ST: begin
                // only power-on reset wakes; everything else is ignored here
                if (por_active) begin
                    next_state.mode = RUN_ST; // [R10]
                    next_state.cpu_halt = 1'b0;
                    next_state.clk_stop = 1'b0;
                    next_state.periph_stop = 1'b0;
                    next_state.port_float = 1'b0;
                end
            end
            default: begin
                next_state.mode = RUN_ST;
            end
        endcase
        // power-on reset restores the register to its reset value;
        // it stands last so the clear beats a write in the same cycle
        if (por_active) begin
            next_state.ctrl = '0; // [R17]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // all outputs low except mode_o, which shows the machine back in run
            state <= '0;
            state.mode <= RUN_ST;
        end else begin
            state <= next_state;
        end
    end

    // every output is a register field, no logic after the flops
    assign dat_o = state.rdata;
    assign ack_o = state.ack;
    assign cpu_halt_o = state.cpu_halt;
    assign clock_stop_o = state.clk_stop;
    assign periph_stop_o = state.periph_stop;
    assign port_float_o = state.port_float;
    assign wake_irq_o = state.wake_irq;
    assign wake_addr_err_o = state.wake_addr_err;
    assign power_on_reset_o = state.por;
    assign manual_reset_o = state.manual_reset_n;
    assign mode_o = state.mode;

    // checks beside the logic they guard
    sleep_entry_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
        (state.mode == RUN_ST && halt_wait_done_i && !state.ctrl.stby_sel
         && pins_sync == 2'b11) |=> (state.mode == SLEEP_ST && !state.clk_stop))
        else $error("sleep not entered");
    standby_entry_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
        (state.mode == RUN_ST && halt_wait_done_i && state.ctrl.stby_sel
         && pins_sync == 2'b11) |=> (state.clk_stop && state.periph_stop && state.cpu_halt))
        else $error("standby not entered");
    cpu_halt_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
        (state.mode != RUN_ST) |-> state.cpu_halt)
        else $error("cpu runs in power-down");
    sleep_periph_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
        (state.mode == SLEEP_ST) |-> !state.periph_stop)
        else $error("peripherals stopped in sleep");
    irq_wake_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
        (state.mode == SLEEP_ST && irq_accept && pins_sync == 2'b11
         && !dma_addr_err_i && !transfer_addr_err_i) |=> (state.mode == RUN_ST && state.wake_irq))
        else $error("interrupt did not wake");
    masked_irq_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
        (state.mode == SLEEP_ST && irq_priority_i <= irq_mask_level_i && pins_sync == 2'b11
         && !dma_addr_err_i && !transfer_addr_err_i) |=> state.mode == SLEEP_ST)
        else $error("masked interrupt woke");
    addr_err_wake_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
        (state.mode == SLEEP_ST && (dma_addr_err_i || transfer_addr_err_i)
         && pins_sync == 2'b11) |=> state.wake_addr_err)
        else $error("address error did not wake");
    standby_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
        (state.mode == STANDBY_ST && pins_sync[1]) |=> state.mode == STANDBY_ST)
        else $error("standby left without power-on reset");
    guard_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
        (wr_lane0 && watchdog_run_enable_i && !state.ctrl.stby_sel && pins_sync[1])
        |=> !state.ctrl.stby_sel)
        else $error("standby_select set while watchdog runs");
    float_guard_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
        (wr_lane0 && watchdog_run_enable_i && !state.ctrl.float_sel && pins_sync[1])
        |=> !state.ctrl.float_sel)
        else $error("port_float_select set while watchdog runs");
    por_clear_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R17]
        por_active |=> (state.ctrl == '0 && state.mode == RUN_ST))
        else $error("power-on reset did not clear");

    // outputs that follow the mode one for one; port_float also follows float_sel on standby entry
    run_clock_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
        (state.mode != STANDBY_ST) |-> (!state.clk_stop && !state.periph_stop))
        else $error("clock stopped outside standby");

    standby_stop_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
        (state.mode == STANDBY_ST) |-> (state.clk_stop && state.periph_stop && state.cpu_halt))
        else $error("standby without full stop");

    run_cpu_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
        (state.mode == RUN_ST) |-> !state.cpu_halt)
        else $error("cpu halted in run");

    float_entry_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
        (state.mode == RUN_ST && halt_wait_done_i && state.ctrl.stby_sel
         && state.ctrl.float_sel && pins_sync == 2'b11) |=> state.port_float)
        else $error("ports not floated in standby");

    hold_entry_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
        (state.mode == RUN_ST && halt_wait_done_i && state.ctrl.stby_sel
         && !state.ctrl.float_sel && pins_sync == 2'b11) |=> !state.port_float)
        else $error("ports floated although held");

    float_only_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
        (state.mode != STANDBY_ST) |-> !state.port_float)
        else $error("ports floated outside standby");

    // wake and reset decode
    irq_block_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
        (state.mode == SLEEP_ST && !irq_source_enabled_i && pins_sync == 2'b11
         && !dma_addr_err_i && !transfer_addr_err_i) |=> state.mode == SLEEP_ST)
        else $error("source-disabled interrupt woke");

    sleep_por_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
        (state.mode == SLEEP_ST && por_active) |=> (state.mode == RUN_ST && !state.cpu_halt))
        else $error("power-on reset did not end sleep");

    sleep_manual_reset_n_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
        (state.mode == SLEEP_ST && manual_reset_n_active) |=> (state.mode == RUN_ST && !state.cpu_halt))
        else $error("manual reset did not end sleep");

    standby_por_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
        (state.mode == STANDBY_ST && por_active)
        |=> (state.mode == RUN_ST && !state.clk_stop && !state.port_float))
        else $error("power-on reset did not end standby");

    standby_manual_reset_n_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
        (state.mode == STANDBY_ST && manual_reset_n_active) |=> state.mode == STANDBY_ST)
        else $error("manual reset ended standby");

    irq_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
        state.wake_irq |=> !state.wake_irq)
        else $error("interrupt wake longer than one cycle");

    err_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
        state.wake_addr_err |=> !state.wake_addr_err)
        else $error("address error wake longer than one cycle");

    manual_reset_n_decode_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
        !pins_sync[1] |=> !state.manual_reset_n)
        else $error("manual reset during power-on reset");

    reset_entry_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
        (state.mode == RUN_ST && (por_active || manual_reset_n_active)) |=> state.mode == RUN_ST)
        else $error("power-down entered during reset");
endmodule : power_down_mode_control

// [sim/cpu_model.sv]
// cpu core stand-in: turns a bench request into the halt-wait completion strobe
// assumes the controller's clock and synchronous active-high reset
module cpu_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sleep_req_i,
    input wire logic cpu_halt_i,
    output logic halt_wait_done_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // one-cycle strobe; a halted core executes nothing, so a request while halted is dropped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            halt_wait_done_o <= 1'b0;
        end else begin
            halt_wait_done_o <= sleep_req_i && !cpu_halt_i && !halt_wait_done_o;
        end
    end
endmodule : cpu_model

// [sim/tb_power_down_mode_control.sv]
// self-checking bench of the power-down controller
// assumes pwrdn_pkg, pwrdn_map.svh and cpu_model; a 40 MHz clock
`include "pwrdn_map.svh"
module tb_power_down_mode_control;
    import pwrdn_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i, rst_i, cyc, stb, we, ack, req, halt_done, wd, pend, src_en, dma_e, xfer_e;
    logic por_n, manual_reset_n_n, cpu_halt, clk_stop, per_stop, float_o, w_irq, w_err, por_o, manual_reset_n_o;
    logic [3:0] sel, prio, mask;
    logic [31:0] adr, wdat, rdat, q;
    logic [2:0] mode;
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;
    cpu_model cpu_u (.clk_i(clk_i), .rst_i(rst_i), .sleep_req_i(req), .cpu_halt_i(cpu_halt),
        .halt_wait_done_o(halt_done));
    power_down_mode_control dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .halt_wait_done_i(halt_done), .watchdog_run_enable_i(wd), .irq_pending_i(pend),
        .irq_source_enabled_i(src_en), .irq_priority_i(prio), .irq_mask_level_i(mask),
        .dma_addr_err_i(dma_e), .transfer_addr_err_i(xfer_e), .power_on_reset_n_i(por_n),
        .manual_reset_n_i(manual_reset_n_n), .cpu_halt_o(cpu_halt), .clock_stop_o(clk_stop),
        .periph_stop_o(per_stop), .port_float_o(float_o), .wake_irq_o(w_irq),
        .wake_addr_err_o(w_err), .power_on_reset_o(por_o), .manual_reset_o(manual_reset_n_o),
        .mode_o(mode));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_sim
    // classic single cycle; held until ack is sampled high, no fixed latency assumed
    task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask : wb
    task automatic wait_mode(input mode_type m);
        for (int n = 0; n < 20 && mode !== m; n++) @(posedge clk_i);
        chk("mode", {29'h0, mode}, {29'h0, m});
    endtask : wait_mode
    task automatic enter(input mode_type m);
        req <= 1'b1;
        @(posedge clk_i);
        req <= 1'b0;
        wait_mode(m);
    endtask : enter
    task automatic t_register;
        wb(0, `PDC_OFFSET, 0); chk("ctrl reset", q, 32'h1F);
        wd <= 1'b1;
        wb(1, `PDC_OFFSET, 32'hDF); wb(0, `PDC_OFFSET, 0); chk("guarded", q, 32'h1F);
        wd <= 1'b0; // watchdog stopped before the select bits are set
        wb(1, `PDC_OFFSET, 32'hDF); wb(0, `PDC_OFFSET, 0); chk("ctrl rw", q, 32'hDF);
        wd <= 1'b1; // clearing stays allowed while the watchdog runs
        wb(1, `PDC_OFFSET, 32'h1F); wb(0, `PDC_OFFSET, 0); chk("ctrl clr", q, 32'h1F);
        wd <= 1'b0;
        wb(0, 32'hFFFF8700, 0); chk("unmapped", q, 32'h0);
    endtask : t_register
    task automatic t_sleep_irq;
        enter(SLEEP_ST);
        chk("halt", cpu_halt, 1);
        chk("periph run", {clk_stop, per_stop}, 0);
        wb(0, `STAT_OFFSET, 0); chk("status sleep", q, {29'h0, SLEEP_ST});
        pend <= 1'b1; prio <= 4'h3; mask <= 4'h3; src_en <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk("equal prio", {29'h0, mode}, {29'h0, SLEEP_ST});
        prio <= 4'h5; src_en <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk("src off", {29'h0, mode}, {29'h0, SLEEP_ST});
        src_en <= 1'b1;
        wait_mode(RUN_ST);
        chk("wake irq", w_irq, 1);
        pend <= 1'b0;
    endtask : t_sleep_irq
    task automatic t_sleep_other;
        for (int i = 0; i < 4; i++) begin
            enter(SLEEP_ST);
            if (i == 0) dma_e <= 1'b1;
            else if (i == 1) xfer_e <= 1'b1;
            else if (i == 2) manual_reset_n_n <= 1'b0;
            else por_n <= 1'b0;
            @(posedge clk_i);
            dma_e <= 1'b0; xfer_e <= 1'b0;
            wait_mode(RUN_ST);
            if (i < 2) chk("wake err", w_err, 1);
            if (i == 2) chk("manual rst", manual_reset_n_o, 1);
            if (i == 3) chk("power rst", por_o, 1);
            manual_reset_n_n <= 1'b1; por_n <= 1'b1;
            repeat (8) @(posedge clk_i);
        end
    endtask : t_sleep_other
    task automatic t_standby(input logic [31:0] v);
        wb(1, `PDC_OFFSET, v);
        enter(STANDBY_ST);
        chk("stops", {cpu_halt, clk_stop, per_stop}, 3'b111);
        chk("float", float_o, v[6]);
        pend <= 1'b1; prio <= 4'hF; mask <= 4'h0; dma_e <= 1'b1; manual_reset_n_n <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk("no wake", {29'h0, mode}, {29'h0, STANDBY_ST});
        chk("no wake pulse", {w_irq, w_err}, 0);
        pend <= 1'b0; dma_e <= 1'b0; manual_reset_n_n <= 1'b1;
        repeat (8) @(posedge clk_i);
        por_n <= 1'b0;
        wait_mode(RUN_ST);
        chk("stops released", {cpu_halt, clk_stop, per_stop, float_o}, 0);
        por_n <= 1'b1;
        repeat (8) @(posedge clk_i);
        wb(0, `PDC_OFFSET, 0); chk("ctrl after por", q, 32'h1F);
    endtask : t_standby
    // reset in mid-run: standby is left and the register is back at its reset value
    task automatic t_reset;
        wb(1, `PDC_OFFSET, 32'h9F); // watchdog already stopped
        enter(STANDBY_ST);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("mode after rst", {29'h0, mode}, {29'h0, RUN_ST});
        chk("outs after rst", {cpu_halt, clk_stop, per_stop, float_o}, 0);
        wb(0, `PDC_OFFSET, 0); chk("ctrl after rst", q, 32'h1F);
    endtask : t_reset
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    // cuts a hang short; the whole run needs well under a thousand cycles
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails++;
            end_sim();
        end
    end
    initial begin
        rst_i <= 1'b1; cyc <= 0; stb <= 0; we <= 0; adr <= 0; wdat <= 0;
        sel <= 0; req <= 0; wd <= 0; pend <= 0; src_en <= 0; prio <= 0; mask <= 0;
        dma_e <= 0; xfer_e <= 0; por_n <= 1; manual_reset_n_n <= 1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (6) @(posedge clk_i); // reset pin synchronisers settle
        t_register();
        t_sleep_irq();
        t_sleep_other();
        t_standby(32'hDF);
        t_standby(32'h9F);
        t_reset();
        end_sim();
    end
endmodule : tb_power_down_mode_control
